// ### rtl/pos_pkg.sv
/*
 Shared constants of the output shutdown unit: register map, field
 positions, request input modes, prescaler masks and pin indices.
 Assumes a 32-bit AHB-Lite register bus and one peripheral clock.
*/
package pos_pkg;
   localparam int NREQ = 4;
   localparam int NPIN = 6;
   localparam int ADDR_W = 12;
   localparam logic [ADDR_W-1:0] ADDR_IN_CTRL  = 12'h000;
   localparam logic [ADDR_W-1:0] ADDR_OUT_CTRL = 12'h004;
   localparam int TRANS_ACT_BIT = 1;
   // input control word fields
   localparam int IN_FLAG_LSB = 12;
   localparam int IN_IE_BIT   = 8;
   localparam int MODE_W      = 2;
   // output control word fields
   localparam int OUT_FLAG_BIT = 15;
   localparam int OUT_CE_BIT   = 9;
   localparam int OUT_IE_BIT   = 8;
   // request input modes
   localparam logic [1:0] MODE_EDGE   = 2'h0;
   localparam logic [1:0] MODE_DIV8   = 2'h1;
   localparam logic [1:0] MODE_DIV16  = 2'h2;
   localparam logic [1:0] MODE_DIV128 = 2'h3;
   // low samples needed, counted 0..15
   localparam int CNT_W = 4;
   localparam logic [3:0] SAMPLE_LAST = 4'hF;
   // prescaler
   localparam int PRE_W = 7;
   localparam logic [6:0] MASK_DIV8   = 7'h07;
   localparam logic [6:0] MASK_DIV16  = 7'h0F;
   localparam logic [6:0] MASK_DIV128 = 7'h7F;
   // high-current pin indices
   localparam int PIN_3B = 0;
   localparam int PIN_3D = 1;
   localparam int PIN_4A = 2;
   localparam int PIN_4B = 3;
   localparam int PIN_4C = 4;
   localparam int PIN_4D = 5;
endpackage

// ### rtl/pos_prescale.sv
/*
 Free running prescaler giving one-cycle sampling ticks at the
 peripheral clock divided by 8, 16 and 128.
 Assumes a single clock and an asynchronous active-low reset.
*/
`timescale 1ns/1ps
module pos_prescale (
   input  wire logic clk,
   input  wire logic nrst,
   output logic      tick8,
   output logic      tick16,
   output logic      tick128
);
   logic [pos_pkg::PRE_W-1:0] cnt_ff;
   logic [pos_pkg::PRE_W-1:0] nxt_cnt;
   logic                      tick8_ff;
   logic                      tick16_ff;
   logic                      tick128_ff;
   logic                      nxt_tick8;
   logic                      nxt_tick16;
   logic                      nxt_tick128;

   // tick when all low bits of the divider are ones
   assign nxt_cnt = cnt_ff + 7'h01;
   assign nxt_tick8 = (cnt_ff & pos_pkg::MASK_DIV8) == pos_pkg::MASK_DIV8;
   assign nxt_tick16 = (cnt_ff & pos_pkg::MASK_DIV16) == pos_pkg::MASK_DIV16;
   assign nxt_tick128 = cnt_ff == pos_pkg::MASK_DIV128;

   // counter and registered ticks
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         cnt_ff     <= 7'h00;
         tick8_ff   <= 1'b0;
         tick16_ff  <= 1'b0;
         tick128_ff <= 1'b0;
      end else begin
         cnt_ff     <= nxt_cnt;
         tick8_ff   <= nxt_tick8;
         tick16_ff  <= nxt_tick16;
         tick128_ff <= nxt_tick128;
      end
   end

   assign tick8   = tick8_ff;
   assign tick16  = tick16_ff;
   assign tick128 = tick128_ff;
endmodule

// ### rtl/pos_top.sv
/*
 Output shutdown unit: watches four active-low request inputs and three
 pairs of timer outputs and forces six high-current pins to high
 impedance; AHB-Lite registers, one level interrupt.
 Assumes inputs synchronous to CLK_SYS and a zero-wait AHB-Lite master.
*/
// The AHB-Lite interface to the registers and the address map are this design's own decisions.
`timescale 1ns/1ps
module pos_top (
   input  wire logic        CLK_SYS,
   input  wire logic        NRST,
   input  wire logic        HSEL,
   input  wire logic [31:0] HADDR,
   input  wire logic [1:0]  HTRANS,
   input  wire logic        HWRITE,
   input  wire logic [2:0]  HSIZE,
   input  wire logic [31:0] HWDATA,
   input  wire logic        HREADY,
   output logic      [31:0] HRDATA,
   output logic             HREADYOUT,
   output logic             HRESP,
   input  wire logic [3:0]  SHUTDOWN_REQUEST_N,
   input  wire logic [5:0]  TIMER_OUT,
   input  wire logic [5:0]  TIMER_OE,
   input  wire logic        OSC_STOP,
   input  wire logic        STANDBY,
   output logic      [5:0]  PIN_OUT,
   output logic      [5:0]  PIN_OE,
   output logic             IRQ
);
   localparam int NR = pos_pkg::NREQ;
   localparam int FL = pos_pkg::IN_FLAG_LSB;

   logic                            tick8;
   logic                            tick16;
   logic                            tick128;
   logic [NR-1:0]                   req_prev_ff;
   logic [NR-1:0]                   accept;
   logic [NR-1:0]                   flag_ff;
   logic [NR-1:0]                   nxt_flag;
   logic [NR-1:0]                   arm_ff;
   logic [NR-1:0]                   nxt_arm;
   logic [2*NR-1:0]                 mode_ff;
   logic                            req_ie_ff;
   logic                            out_flag_ff;
   logic                            nxt_out_flag;
   logic                            out_arm_ff;
   logic                            nxt_out_arm;
   logic                            cmp_en_ff;
   logic                            out_ie_ff;
   logic                            pair_low;
   logic [pos_pkg::NPIN-1:0]        drv_low;
   logic                            shut;
   logic                            irq_cond;
   logic                            addr_ok;
   logic                            wr_ph_ff;
   logic [pos_pkg::ADDR_W-1:0]      haddr_ff;
   logic                            wr_in;
   logic                            wr_out;
   logic                            rd_in;
   logic                            rd_out;
   logic [31:0]                     in_word;
   logic [31:0]                     out_word;
   logic [31:0]                     nxt_rdata;
   logic [31:0]                     rdata_ff;
   logic                            readyout_ff;
   logic [NR-1:0]                   wr_flag_zero;
   logic [5:0]                      pin_out_ff;
   logic [5:0]                      pin_oe_ff;
   logic                            irq_ff;

   // selects the sampling tick of a mode; edge mode has none
   function automatic logic mode_tick(input logic [1:0] m,
                                      input logic t8,
                                      input logic t16,
                                      input logic t128);
      logic t;
      t = 1'b0;
      case (m)
         pos_pkg::MODE_DIV8:   t = t8;
         pos_pkg::MODE_DIV16:  t = t16;
         pos_pkg::MODE_DIV128: t = t128;
         default:              t = 1'b0;
      endcase
      return t;
   endfunction

   pos_prescale u_pre (
      .clk     (CLK_SYS),
      .nrst    (NRST),
      .tick8   (tick8),
      .tick16  (tick16),
      .tick128 (tick128)
   );

   // bus decode: reads in the address phase, writes in the data phase
   assign addr_ok = HSEL & HTRANS[pos_pkg::TRANS_ACT_BIT] & HREADY;
   assign rd_in  = addr_ok & ~HWRITE
                   & (HADDR[11:0] == pos_pkg::ADDR_IN_CTRL);
   assign rd_out = addr_ok & ~HWRITE
                   & (HADDR[11:0] == pos_pkg::ADDR_OUT_CTRL);
   assign wr_in  = wr_ph_ff & (haddr_ff == pos_pkg::ADDR_IN_CTRL);
   assign wr_out = wr_ph_ff & (haddr_ff == pos_pkg::ADDR_OUT_CTRL);

   // readable words; reserved bits read as zero
   assign in_word = {16'h0000, flag_ff, 3'h0, req_ie_ff, mode_ff};
   assign out_word = {16'h0000, out_flag_ff, 5'h00, cmp_en_ff,
                      out_ie_ff, 8'h00};
   assign nxt_rdata = rd_in ? in_word : (rd_out ? out_word : 32'h0000_0000);

   // bus phase registers; reply is zero-wait and always okay
   always_ff @(posedge CLK_SYS or negedge NRST) begin
      if (!NRST) begin
         wr_ph_ff    <= 1'b0;
         haddr_ff    <= 12'h000;
         rdata_ff    <= 32'h0000_0000;
         readyout_ff <= 1'b0;
      end else begin
         wr_ph_ff    <= addr_ok & HWRITE;
         haddr_ff    <= HADDR[11:0];
         rdata_ff    <= nxt_rdata;
         readyout_ff <= 1'b1;
      end
   end

   // control bits written by software
   always_ff @(posedge CLK_SYS or negedge NRST) begin
      if (!NRST) begin
         mode_ff   <= 8'h00;
         req_ie_ff <= 1'b0;
         cmp_en_ff <= 1'b0;
         out_ie_ff <= 1'b0;
      end else begin
         if (wr_in) begin
            mode_ff   <= HWDATA[2*NR-1:0];
            req_ie_ff <= HWDATA[pos_pkg::IN_IE_BIT];
         end
         if (wr_out) begin
            cmp_en_ff <= HWDATA[pos_pkg::OUT_CE_BIT];
            out_ie_ff <= HWDATA[pos_pkg::OUT_IE_BIT];
         end
      end
   end

   // one detector per request input
   genvar gi;
   generate
      for (gi = 0; gi < NR; gi++) begin : g_req
         logic [pos_pkg::CNT_W-1:0] cnt_ff;
         logic [pos_pkg::CNT_W-1:0] nxt_cnt;
         logic [1:0]                mode;
         logic                      tick;
         logic                      is_low;
         logic                      fall;
         logic                      samp_acc;

         assign mode = mode_ff[2*gi +: 2];
         assign tick = mode_tick(mode, tick8, tick16, tick128);
         assign is_low = ~SHUTDOWN_REQUEST_N[gi];
         assign fall = req_prev_ff[gi] & is_low;
         // sixteenth consecutive low sample accepts
         assign samp_acc = tick & is_low
                           & (cnt_ff == pos_pkg::SAMPLE_LAST);
         assign accept[gi] = (mode == pos_pkg::MODE_EDGE) ? fall
                                                          : samp_acc;
         // high sample restarts the count
         assign nxt_cnt = !tick ? cnt_ff :
                          (!is_low || samp_acc) ? 4'h0 :
                          cnt_ff + 4'h1;

         // sample counter and previous level for edge detection
         always_ff @(posedge CLK_SYS or negedge NRST) begin
            if (!NRST) begin
               cnt_ff          <= 4'h0;
               req_prev_ff[gi] <= 1'b1;
            end else begin
               cnt_ff          <= (mode == pos_pkg::MODE_EDGE) ? 4'h0
                                                               : nxt_cnt;
               req_prev_ff[gi] <= SHUTDOWN_REQUEST_N[gi];
            end
         end

         // the tick before an accept must have seen a low sample
         AST_SAMPLE_COUNT:
         assert property (@(posedge CLK_SYS) disable iff (!NRST)
            (mode == pos_pkg::MODE_DIV8) && accept[gi]
            && ($past(mode, 8) == pos_pkg::MODE_DIV8)
            |-> $past(is_low, 8) && (cnt_ff == pos_pkg::SAMPLE_LAST))
         else $error("sample accept after a high sample");

         AST_EDGE_SET:
         assert property (@(posedge CLK_SYS) disable iff (!NRST)
            (mode == pos_pkg::MODE_EDGE) && req_prev_ff[gi] && is_low
            |=> flag_ff[gi])
         else $error("falling edge did not set request flag");

         AST_FLAG_HOLD:
         assert property (@(posedge CLK_SYS) disable iff (!NRST)
            flag_ff[gi] && !arm_ff[gi] |=> flag_ff[gi])
         else $error("request flag cleared without prior read");
      end
   endgenerate

   // flags clear on a zero write only after a read showed them set;
   // a new accept in the same cycle wins over the clear
   assign wr_flag_zero = {NR{wr_in}} & ~HWDATA[FL +: NR];
   assign nxt_flag = accept | (flag_ff & ~(wr_flag_zero & arm_ff));
   assign nxt_arm = (rd_in ? flag_ff : arm_ff) & ~{NR{wr_in}} & nxt_flag;

   // output comparison over the three monitored pairs
   assign drv_low = TIMER_OE & ~TIMER_OUT;
   assign pair_low = (drv_low[pos_pkg::PIN_3B] & drv_low[pos_pkg::PIN_3D])
                   | (drv_low[pos_pkg::PIN_4A] & drv_low[pos_pkg::PIN_4C])
                   | (drv_low[pos_pkg::PIN_4B]
                      & drv_low[pos_pkg::PIN_4D]);
   assign nxt_out_flag = (cmp_en_ff & pair_low)
                       | (out_flag_ff & ~(wr_out & out_arm_ff
                          & ~HWDATA[pos_pkg::OUT_FLAG_BIT]));
   assign nxt_out_arm = (rd_out ? out_flag_ff : out_arm_ff) & ~wr_out
                        & nxt_out_flag;

   // status flags and their read arms
   always_ff @(posedge CLK_SYS or negedge NRST) begin
      if (!NRST) begin
         flag_ff     <= 4'h0;
         arm_ff      <= 4'h0;
         out_flag_ff <= 1'b0;
         out_arm_ff  <= 1'b0;
      end else begin
         flag_ff     <= nxt_flag;
         arm_ff      <= nxt_arm;
         out_flag_ff <= nxt_out_flag;
         out_arm_ff  <= nxt_out_arm;
      end
   end

   // shutdown of all six pins and interrupt request
   assign shut = (|flag_ff) | out_flag_ff | OSC_STOP | STANDBY;
   assign irq_cond = ((|flag_ff) & req_ie_ff)
                   | (out_flag_ff & out_ie_ff);

   // registered pin drive
   always_ff @(posedge CLK_SYS or negedge NRST) begin
      if (!NRST) begin
         pin_out_ff <= 6'h00;
         pin_oe_ff  <= 6'h00;
         irq_ff     <= 1'b0;
      end else begin
         pin_out_ff <= TIMER_OUT;
         pin_oe_ff  <= shut ? 6'h00 : TIMER_OE;
         irq_ff     <= irq_cond;
      end
   end

   assign PIN_OUT   = pin_out_ff;
   assign PIN_OE    = pin_oe_ff;
   assign IRQ       = irq_ff;
   assign HRDATA    = rdata_ff;
   assign HREADYOUT = readyout_ff;
   assign HRESP     = 1'b0;

   AST_REQ_HIZ:
   assert property (@(posedge CLK_SYS) disable iff (!NRST)
      (|flag_ff) |=> PIN_OE == 6'h00)
   else $error("pins driven while request flag set");

   AST_PAIR_LOW:
   assert property (@(posedge CLK_SYS) disable iff (!NRST)
      cmp_en_ff && drv_low[pos_pkg::PIN_4B] && drv_low[pos_pkg::PIN_4D]
      |=> out_flag_ff ##1 PIN_OE == 6'h00)
   else $error("pair low did not shut pins");

   AST_PAIR_3:
   assert property (@(posedge CLK_SYS) disable iff (!NRST)
      cmp_en_ff && drv_low[pos_pkg::PIN_3B] && drv_low[pos_pkg::PIN_3D]
      |=> out_flag_ff)
   else $error("timer3 pair low not flagged");

   AST_OSC_HIZ:
   assert property (@(posedge CLK_SYS) disable iff (!NRST)
      OSC_STOP || STANDBY |=> PIN_OE == 6'h00)
   else $error("pins driven during oscillator stop or standby");

   AST_PASS:
   assert property (@(posedge CLK_SYS) disable iff (!NRST)
      NRST && !shut
      |=> PIN_OE == $past(TIMER_OE) && PIN_OUT == $past(TIMER_OUT))
   else $error("pins not following timer while not shut");

   AST_IRQ_SET:
   assert property (@(posedge CLK_SYS) disable iff (!NRST)
      (|flag_ff) && req_ie_ff |=> IRQ)
   else $error("interrupt missing for enabled request flag");

   AST_IRQ_OUT:
   assert property (@(posedge CLK_SYS) disable iff (!NRST)
      !(out_flag_ff && out_ie_ff) && !((|flag_ff) && req_ie_ff) |=> !IRQ)
   else $error("interrupt without enabled flag");
endmodule

// ### verif/pos_far_side.sv
/*
 Far side of the shutdown unit: request sources and timer output stage.
 Assumes the bench commands request lines and pair faults at CLK_SYS.
*/
`timescale 1ns/1ps
module pos_far_side (
   input  wire logic       clk,
   input  wire logic [3:0] req_low,
   input  wire logic [2:0] pair_low,
   input  wire logic [5:0] oe_off,
   output logic      [3:0] req_n,
   output logic      [5:0] tout,
   output logic      [5:0] toe
);
   logic ph_ff = 1'b0;
   // output stage phase, flips every cycle
   always_ff @(posedge clk) begin
      ph_ff <= ~ph_ff;
   end
   // request lines rest at the pull-up level unless commanded low
   assign req_n = ~req_low;
   // timer drives every pin unless the bench turns some enables off
   assign toe   = ~oe_off;
   // pairs (0,1) (2,4) (3,5) are complementary unless a fault forces both low
   assign tout = {~ph_ff & ~pair_low[2], ~ph_ff & ~pair_low[1],
                  ph_ff & ~pair_low[2], ph_ff & ~pair_low[1],
                  ~ph_ff & ~pair_low[0], ph_ff & ~pair_low[0]};
endmodule

// ### verif/tb_top.sv
/*
 Self-checking bench of the shutdown unit: request table, then masking,
 pair compare, oscillator stop, standby and a second reset.
 Assumes one AHB-Lite slave whose HREADYOUT is the bus ready.
*/
`timescale 1ns/1ps
module tb_top;
   typedef struct {
      int         idx;
      logic [1:0] mode;
      int         low1;
      int         gap;
      int         low2;
      logic       hit;
   } pos_row_type;
   logic        CLK_SYS = 1'b0;
   logic        NRST = 1'b0;
   logic        HSEL = 1'b0;
   logic        HWRITE = 1'b0;
   logic [31:0] HADDR = 32'h0;
   logic [31:0] HWDATA = 32'h0;
   logic [1:0]  HTRANS = 2'h0;
   logic        OSC_STOP = 1'b0;
   logic        STANDBY = 1'b0;
   logic [3:0]  req_low = 4'h0;
   logic [2:0]  pair_low = 3'h0;
   logic [5:0]  oe_off = 6'h00;
   logic [31:0] HRDATA, rd, cfg, exp;
   logic        HREADYOUT, HRESP, IRQ;
   logic [3:0]  req_n;
   logic [5:0]  tout, toe, PIN_OUT, PIN_OE;
   int          mismatches = 0;
   int          n_compared = 0;
   pos_row_type rows [7] = '{
      '{0, pos_pkg::MODE_EDGE,   2,    0,  0,  1'b1},
      '{1, pos_pkg::MODE_DIV8,   136,  0,  0,  1'b1},
      '{2, pos_pkg::MODE_DIV8,   104,  0,  0,  1'b0},
      '{2, pos_pkg::MODE_DIV8,   80,   16, 80, 1'b0},
      '{3, pos_pkg::MODE_DIV16,  272,  0,  0,  1'b1},
      '{1, pos_pkg::MODE_DIV16,  208,  0,  0,  1'b0},
      '{0, pos_pkg::MODE_DIV128, 2176, 0,  0,  1'b1}};
   // clock
   always #20 CLK_SYS = ~CLK_SYS;
   pos_top pos_top_inst (.CLK_SYS(CLK_SYS), .NRST(NRST), .HSEL(HSEL),
      .HADDR(HADDR), .HTRANS(HTRANS), .HWRITE(HWRITE), .HSIZE(3'h2),
      .HWDATA(HWDATA), .HREADY(HREADYOUT), .HRDATA(HRDATA),
      .HREADYOUT(HREADYOUT), .HRESP(HRESP), .SHUTDOWN_REQUEST_N(req_n),
      .TIMER_OUT(tout), .TIMER_OE(toe), .OSC_STOP(OSC_STOP),
      .STANDBY(STANDBY), .PIN_OUT(PIN_OUT), .PIN_OE(PIN_OE), .IRQ(IRQ));
   pos_far_side pos_far_side_inst (.clk(CLK_SYS), .req_low(req_low),
      .pair_low(pair_low), .oe_off(oe_off), .req_n(req_n), .tout(tout),
      .toe(toe));
   // verdict and end of run
   task automatic wrap_up();
      $display("mismatches %0d compared %0d", mismatches, n_compared);
      if (mismatches == 0 && n_compared > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask
   // compare and count
   task automatic chk(input logic [31:0] got, input logic [31:0] want,
                      input string m);
      n_compared++;
      if (got !== want) begin
         mismatches++;
         $display("BAD %0t %s got %h want %h", $time, m, got, want);
      end
   endtask
   // wait a number of rising edges
   task automatic cyc(input int n);
      repeat (n) @(posedge CLK_SYS);
   endtask
   // one AHB-Lite single word transfer, read data left in rd
   task automatic bus(input logic wr, input logic [11:0] a,
                      input logic [31:0] wd);
      @(posedge CLK_SYS);
      HSEL <= 1'b1;
      HADDR <= {20'h0, a};
      HTRANS <= 2'h2;
      HWRITE <= wr;
      do @(posedge CLK_SYS); while (HREADYOUT !== 1'b1);
      HSEL <= 1'b0;
      HTRANS <= 2'h0;
      HWDATA <= wd;
      do @(posedge CLK_SYS); while (HREADYOUT !== 1'b1);
      rd = HRDATA;
   endtask
   // two-cycle pulse on a request line
   task automatic pulse(input int i);
      req_low[i] <= 1'b1;
      cyc(2);
      req_low[i] <= 1'b0;
      cyc(4);
   endtask
   // watchdog
   initial begin
      #(40 * 30000);
      mismatches++;
      $display("BAD %0t watchdog expired", $time);
      wrap_up();
   end
   // main sequence
   initial begin
      cyc(10);
      chk(32'(PIN_OE), 32'h0, "oe in reset");
      chk(32'(HREADYOUT), 32'h0, "ready in reset");
      NRST <= 1'b1;
      cyc(2);
      bus(1'b0, pos_pkg::ADDR_IN_CTRL, 32'h0);
      chk(rd, 32'h0, "in ctrl reset");
      chk(32'(HRESP), 32'h0, "okay response");
      bus(1'b0, pos_pkg::ADDR_OUT_CTRL, 32'h0);
      chk(rd, 32'h0, "out ctrl reset");
      bus(1'b1, 12'h008, 32'hFFFF);
      bus(1'b0, 12'h008, 32'h0);
      chk(rd, 32'h0, "unmapped");
      // table of request inputs, modes and low spans
      for (int r = 0; r < 7; r++) begin
         cfg = 32'h100 | (32'(rows[r].mode) << (2 * rows[r].idx));
         bus(1'b1, pos_pkg::ADDR_IN_CTRL, cfg);
         req_low[rows[r].idx] <= 1'b1;
         cyc(rows[r].low1);
         req_low[rows[r].idx] <= 1'b0;
         cyc(rows[r].gap);
         if (rows[r].low2 > 0) begin
            req_low[rows[r].idx] <= 1'b1;
            cyc(rows[r].low2);
            req_low[rows[r].idx] <= 1'b0;
         end
         cyc(4);
         exp = cfg | (32'(rows[r].hit) << (12 + rows[r].idx));
         bus(1'b0, pos_pkg::ADDR_IN_CTRL, 32'h0);
         chk(rd, exp, "request flag");
         chk(32'(IRQ), 32'(rows[r].hit), "request irq");
         exp = rows[r].hit ? 32'h0 : 32'h3F;
         chk(32'(PIN_OE), exp, "request oe");
         bus(1'b1, pos_pkg::ADDR_IN_CTRL, cfg);
         cyc(3);
         chk(32'(PIN_OE), 32'h3F, "oe after clear");
         chk(32'(IRQ), 32'h0, "irq after clear");
      end
      // masked request, and clear without a prior read
      bus(1'b1, pos_pkg::ADDR_IN_CTRL, 32'h0);
      pulse(0);
      chk(32'(IRQ), 32'h0, "masked irq");
      bus(1'b1, pos_pkg::ADDR_IN_CTRL, 32'h0);
      bus(1'b0, pos_pkg::ADDR_IN_CTRL, 32'h0);
      chk(rd, 32'h1000, "flag kept");
      bus(1'b1, pos_pkg::ADDR_IN_CTRL, 32'h0);
      bus(1'b0, pos_pkg::ADDR_IN_CTRL, 32'h0);
      chk(rd, 32'h0, "flag cleared");
      // each pair low together for one cycle
      for (int p = 0; p < 3; p++) begin
         bus(1'b1, pos_pkg::ADDR_OUT_CTRL, 32'h300);
         pair_low[p] <= 1'b1;
         cyc(1);
         pair_low[p] <= 1'b0;
         cyc(3);
         chk(32'(PIN_OE), 32'h0, "pair shut");
         chk(32'(IRQ), 32'h1, "pair irq");
         bus(1'b0, pos_pkg::ADDR_OUT_CTRL, 32'h0);
         chk(rd, 32'h8300, "pair flag");
         bus(1'b1, pos_pkg::ADDR_OUT_CTRL, 32'h300);
         cyc(3);
         chk(32'(PIN_OE), 32'h3F, "pair released");
      end
      // compare disabled: a pair fault is ignored
      bus(1'b1, pos_pkg::ADDR_OUT_CTRL, 32'h100);
      pair_low[1] <= 1'b1;
      cyc(1);
      pair_low[1] <= 1'b0;
      cyc(3);
      chk(32'(PIN_OE), 32'h3F, "compare off");
      // a pair whose outputs are not driven is no fault; enables pass on
      bus(1'b1, pos_pkg::ADDR_OUT_CTRL, 32'h300);
      oe_off <= 6'h28;
      pair_low[2] <= 1'b1;
      cyc(1);
      pair_low[2] <= 1'b0;
      cyc(3);
      chk(32'(PIN_OE), 32'h17, "undriven pair");
      // output levels reach the pins one cycle later
      exp = 32'(tout);
      cyc(1);
      chk(32'(PIN_OUT), exp, "pin follows timer");
      oe_off <= 6'h00;
      cyc(3);
      // oscillator stop, then standby
      for (int s = 0; s < 2; s++) begin
         {STANDBY, OSC_STOP} <= 2'(1 << s);
         cyc(3);
         chk(32'(PIN_OE), 32'h0, "stop shut");
         {STANDBY, OSC_STOP} <= 2'h0;
         cyc(3);
         chk(32'(PIN_OE), 32'h3F, "stop released");
      end
      // second reset with a flag set
      bus(1'b1, pos_pkg::ADDR_IN_CTRL, 32'h0);
      pulse(3);
      NRST <= 1'b0;
      cyc(2);
      chk(32'(PIN_OE), 32'h0, "oe in second reset");
      NRST <= 1'b1;
      cyc(2);
      bus(1'b0, pos_pkg::ADDR_IN_CTRL, 32'h0);
      chk(rd, 32'h0, "flags after reset");
      wrap_up();
   end
endmodule
